// *** ppfs_consts.svh ***
// Register offsets, field positions and reset values for the port pin share block
`ifndef PPFS_CONSTS_SVH
`define PPFS_CONSTS_SVH
`define PPFS_OFF_P0_DATA 8'h00
`define PPFS_OFF_P1_DATA 8'h04
`define PPFS_OFF_P0_DIR 8'h08
`define PPFS_OFF_P1_DIR 8'h0C
`define PPFS_OFF_P0_PULL 8'h10
`define PPFS_OFF_P1_PULL 8'h14
`define PPFS_OFF_P0_OMODE 8'h18
`define PPFS_OFF_ENABLES 8'h1C
`define PPFS_OFF_P0_OWNED 8'h20
`define PPFS_OFF_P1_OWNED 8'h24
`define PPFS_OFF_P0_PIN 8'h28
`define PPFS_OFF_P1_PIN 8'h2C
`define PPFS_OFF_RMW_READ 8'h30
`define PPFS_EN_IRQ2 0
`define PPFS_EN_IRQ3 1
`define PPFS_EN_IRQ1 2
`define PPFS_EN_GRP4 3
`define PPFS_EN_CONV_ON 4
`define PPFS_EN_T1_RUN 5
`define PPFS_EN_T1_CNT 6
`define PPFS_EN_T0_RUN 7
`define PPFS_EN_T0_CNT 8
`define PPFS_EN_PWM2C 9
`define PPFS_EN_REF 10
`define PPFS_EN_SEL_LSB 11
`define PPFS_EN_SRC_LSB 16
`define PPFS_EN_ACH_LSB 24
`define PPFS_RESET_BYTE 8'h00
`define PPFS_RESET_WORD 32'h0000_0000
`define PPFS_RESP_OKAY 2'b00
`define PPFS_RESP_SLVERR 2'b10
`endif

// *** ppfs_pin_cell.sv ***
// One shared pin: drive, pull-up and open-drain resolution
`timescale 1ns/1ps
module ppfs_pin_cell (
  input wire logic i_owned,
  input wire logic i_alt_drive,
  input wire logic i_alt_value,
  input wire logic i_alt_pullup,
  input wire logic i_data,
  input wire logic i_dir_out,
  input wire logic i_pull_en,
  input wire logic i_open_drain,
  output logic o_oe,
  output logic o_out,
  output logic o_pullup
);
  // Owner decides the pin; stored direction/pull bits wait until released
  always_comb
  begin
    if (i_owned)
    begin
      o_oe = i_alt_drive; // R7 R8
      o_out = i_alt_value;
      o_pullup = i_alt_pullup; // R6
    end
    else
    begin
      o_oe = i_dir_out && !(i_open_drain && i_data); // R20 R14 R22
      o_out = i_data;
      o_pullup = i_pull_en && !i_dir_out; // R21
    end
  end
endmodule

// *** ppfs_pin_model.sv ***
// Behavioural model of the board circuitry on one shared 8-bit port
`timescale 1ns/1ps
module ppfs_pin_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pullup,
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_pin
);
  logic [7:0] float_r = 8'h5A;
  // A floating line wanders every cycle so no reader can rely on a stale level
  always @(posedge i_core_clk)
  begin
    float_r <= ~float_r;
  end
  // Device drive wins, then the board driver, then the pull-up
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
    | (~i_oe & ~i_ext_en & (i_pullup | float_r));
endmodule

// *** ppfs_pkg.sv ***
// Types shared by the port pin share block
package ppfs_pkg;
  typedef enum logic [2:0] {
    PPFS_OWN_IO,
    PPFS_OWN_IRQ_IN,
    PPFS_OWN_ANALOG,
    PPFS_OWN_COUNT_IN,
    PPFS_OWN_PWM_OUT,
    PPFS_OWN_REF_IN,
    PPFS_OWN_RESET
  } ppfs_owner_t;
endpackage

// *** ppfs_port_share.sv ***
// Port 0/1 pin sharing, read path and AXI4-Lite register slave
//
// Behaviour
// R1: Input-mode bit read returns the pin level.
// R2: Output-mode read: RMW reads latch, other reads return pin.
// R3: Every port write updates the data latch, even when pin is taken.
// R4: Highest-priority enabled function owns each shared pin.
// R5: Pin passes lower only after higher function is disabled.
// R6: Automatic pull-up follows the same priority arbitration.
// R7: Direction and pull-up writes are stored but held off while owned.
// R8: While owned, port accesses touch only the latch, pin unchanged.
// R9: P0.0 is interrupt 2 input when enabled and in input mode.
// R10: P0.1 is interrupt 3 input when enabled and in input mode.
// R11: P0.2-5 are analog 0-3 with channel enable, converter on, select match.
// R12: P0.6 is timer 1 count input with pull-up when run and counter set.
// R13: P0.7: PWM2 complement first, then interrupt 1 in input mode, else I/O.
// R14: Analog-capable port 0 pins are open drain when mode bit is 0.
// R15: P1.0/P1.1 are group 4 sources 7/4 when enabled, selected, input mode.
// R16: P1.2-5 first serve group 4 sources 3-0 when enabled, selected, input.
// R17: Else P1.2-5 are analog 4-7 with enable, converter on, select match.
// R18: P1.6: timer 0 count input first, then reference input, else I/O.
// R19: P1.7 is reset or I/O by a fixed configuration option only.
// R20: Direction bit 0 means input, 1 means output.
// R21: Pull-up bit 1 enables the internal pull-up on inputs.
// R22: Port 0 mode bit 0 is open drain, 1 is push-pull.
// R23: Ownership is combinational from current enables every cycle.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ppfs_consts.svh"
module ppfs_port_share #(
  parameter int ADDR_W = 8,
  parameter bit P17_IS_RESET = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [7:0] i_p0_pin,
  input wire logic [7:0] i_p1_pin,
  input wire logic i_pwm2_complement_output,
  output logic [7:0] o_p0_out,
  output logic [7:0] o_p0_oe,
  output logic [7:0] o_p0_pullup,
  output logic [7:0] o_p1_out,
  output logic [7:0] o_p1_oe,
  output logic [7:0] o_p1_pullup,
  output logic o_ext_irq1_input,
  output logic o_ext_irq2_input,
  output logic o_ext_irq3_input,
  output logic [7:0] o_group4_source_input,
  output logic [7:0] o_analog_input_sel,
  output logic o_timer0_count_input,
  output logic o_timer1_count_input,
  output logic o_reference_input_sel,
  output logic o_system_reset_request
);
  // Software-visible state
  logic [7:0] p0_data_r;
  logic [7:0] p1_data_r;
  logic [7:0] p0_dir_r;
  logic [7:0] p1_dir_r;
  logic [7:0] p0_pull_r;
  logic [7:0] p1_pull_r;
  logic [3:0] p0_omode_r;
  logic [31:0] enables_r;
  // Bus slave state
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic rmw_mode_r;
  logic p17_reset_r;
  // Ownership, recomputed every cycle
  ppfs_pkg::ppfs_owner_t p0_owner [8];
  ppfs_pkg::ppfs_owner_t p1_owner [8];
  logic [7:0] p0_owned;
  logic [7:0] p1_owned;
  logic [7:0] p0_alt_drive;
  logic [7:0] p0_alt_value;
  logic [7:0] p0_alt_pull;
  logic [7:0] p1_alt_pull;
  logic [7:0] p0_oe_nxt;
  logic [7:0] p0_out_nxt;
  logic [7:0] p0_pull_nxt;
  logic [7:0] p1_oe_nxt;
  logic [7:0] p1_out_nxt;
  logic [7:0] p1_pull_nxt;
  logic [2:0] ch_sel;
  logic [7:0] ach_en;
  logic [7:0] src_sel;
  logic grp4_en;
  logic conv_on;
  logic wr_fire;
  logic [7:0] p0_read;
  logic [7:0] p1_read;

  assign ch_sel = enables_r[`PPFS_EN_SEL_LSB +: 3];
  assign ach_en = enables_r[`PPFS_EN_ACH_LSB +: 8];
  assign src_sel = enables_r[`PPFS_EN_SRC_LSB +: 8];
  assign grp4_en = enables_r[`PPFS_EN_GRP4];
  assign conv_on = enables_r[`PPFS_EN_CONV_ON];

  // Port 0 arbitration; first true branch wins, so lower ones wait
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      p0_owner[i] = ppfs_pkg::PPFS_OWN_IO;
    end
    if (enables_r[`PPFS_EN_IRQ2] && !p0_dir_r[0])
    begin
      p0_owner[0] = ppfs_pkg::PPFS_OWN_IRQ_IN; // R9
    end
    if (enables_r[`PPFS_EN_IRQ3] && !p0_dir_r[1])
    begin
      p0_owner[1] = ppfs_pkg::PPFS_OWN_IRQ_IN; // R10
    end
    for (int i = 0; i < 4; i++)
    begin
      if (ach_en[i] && conv_on && (ch_sel == 3'(i)))
      begin
        p0_owner[i+2] = ppfs_pkg::PPFS_OWN_ANALOG; // R11
      end
    end
    if (enables_r[`PPFS_EN_T1_RUN] && enables_r[`PPFS_EN_T1_CNT])
    begin
      p0_owner[6] = ppfs_pkg::PPFS_OWN_COUNT_IN; // R12
    end
    if (enables_r[`PPFS_EN_PWM2C])
    begin
      p0_owner[7] = ppfs_pkg::PPFS_OWN_PWM_OUT; // R13 R4 R5
    end
    else if (enables_r[`PPFS_EN_IRQ1] && !p0_dir_r[7])
    begin
      p0_owner[7] = ppfs_pkg::PPFS_OWN_IRQ_IN; // R13
    end
  end

  // Port 1 arbitration
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      p1_owner[i] = ppfs_pkg::PPFS_OWN_IO;
    end
    if (grp4_en && src_sel[7] && !p1_dir_r[0])
    begin
      p1_owner[0] = ppfs_pkg::PPFS_OWN_IRQ_IN; // R15
    end
    if (grp4_en && src_sel[4] && !p1_dir_r[1])
    begin
      p1_owner[1] = ppfs_pkg::PPFS_OWN_IRQ_IN; // R15
    end
    for (int i = 0; i < 4; i++)
    begin
      if (grp4_en && src_sel[3-i] && !p1_dir_r[i+2])
      begin
        p1_owner[i+2] = ppfs_pkg::PPFS_OWN_IRQ_IN; // R16 R4
      end
      else if (ach_en[i+4] && conv_on && (ch_sel == 3'(i+4)))
      begin
        p1_owner[i+2] = ppfs_pkg::PPFS_OWN_ANALOG; // R17 R5
      end
    end
    if (enables_r[`PPFS_EN_T0_RUN] && enables_r[`PPFS_EN_T0_CNT])
    begin
      p1_owner[6] = ppfs_pkg::PPFS_OWN_COUNT_IN; // R18
    end
    else if (enables_r[`PPFS_EN_REF])
    begin
      p1_owner[6] = ppfs_pkg::PPFS_OWN_REF_IN; // R18
    end
    if (p17_reset_r)
    begin
      p1_owner[7] = ppfs_pkg::PPFS_OWN_RESET; // R19
    end
  end

  // Per-bit ownership flags and alternate drive/pull; R23 keeps it combinational
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bit
      assign p0_owned[g] = (p0_owner[g] != ppfs_pkg::PPFS_OWN_IO); // R23
      assign p1_owned[g] = (p1_owner[g] != ppfs_pkg::PPFS_OWN_IO); // R23
      assign p0_alt_drive[g] = (p0_owner[g] == ppfs_pkg::PPFS_OWN_PWM_OUT);
      assign p0_alt_value[g] = (g == 7) ? i_pwm2_complement_output : 1'b0;
      assign p0_alt_pull[g] = (p0_owner[g] == ppfs_pkg::PPFS_OWN_COUNT_IN); // R6
      assign p1_alt_pull[g] = (p1_owner[g] == ppfs_pkg::PPFS_OWN_COUNT_IN)
        || (p1_owner[g] == ppfs_pkg::PPFS_OWN_RESET); // R6
      ppfs_pin_cell u_p0_cell (
        .i_owned(p0_owned[g]),
        .i_alt_drive(p0_alt_drive[g]),
        .i_alt_value(p0_alt_value[g]),
        .i_alt_pullup(p0_alt_pull[g]),
        .i_data(p0_data_r[g]),
        .i_dir_out(p0_dir_r[g]),
        .i_pull_en(p0_pull_r[g]),
        .i_open_drain((g >= 2 && g <= 5) ? !p0_omode_r[(g >= 2 && g <= 5) ? g-2 : 0] : 1'b0),
        .o_oe(p0_oe_nxt[g]),
        .o_out(p0_out_nxt[g]),
        .o_pullup(p0_pull_nxt[g])
      );
      ppfs_pin_cell u_p1_cell (
        .i_owned(p1_owned[g]),
        .i_alt_drive(1'b0),
        .i_alt_value(1'b0),
        .i_alt_pullup(p1_alt_pull[g]),
        .i_data(p1_data_r[g]),
        .i_dir_out(p1_dir_r[g]),
        .i_pull_en(p1_pull_r[g]),
        .i_open_drain(1'b0),
        .o_oe(p1_oe_nxt[g]),
        .o_out(p1_out_nxt[g]),
        .o_pullup(p1_pull_nxt[g])
      );
    end
  endgenerate

  // Pin level for input bits; output bits give latch only in RMW read mode
  assign p0_read = (p0_dir_r & {8{rmw_mode_r}} & p0_data_r)
    | (~(p0_dir_r & {8{rmw_mode_r}}) & i_p0_pin); // R1 R2
  assign p1_read = (p1_dir_r & {8{rmw_mode_r}} & p1_data_r)
    | (~(p1_dir_r & {8{rmw_mode_r}}) & i_p1_pin); // R1 R2

  // Reset-or-I/O choice caught once out of reset, never written by software
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      p17_reset_r <= P17_IS_RESET; // R19
    end
  end

  // Write address and data are accepted independently, then paired
  assign wr_fire = aw_held_r && w_held_r && !o_s_axi_bvalid;
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= `PPFS_RESET_WORD;
      wstrb_r <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `PPFS_RESP_OKAY;
    end
    else
    begin
      o_s_axi_awready <= !aw_held_r && !o_s_axi_awready;
      o_s_axi_wready <= !w_held_r && !o_s_axi_wready;
      if (o_s_axi_awready && i_s_axi_awvalid)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= i_s_axi_awaddr;
      end
      if (o_s_axi_wready && i_s_axi_wvalid)
      begin
        w_held_r <= 1'b1;
        wdata_r <= i_s_axi_wdata;
        wstrb_r <= i_s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= (awaddr_r[7:0] <= `PPFS_OFF_RMW_READ && awaddr_r[1:0] == 2'b00)
          ? `PPFS_RESP_OKAY : `PPFS_RESP_SLVERR;
      end
      else if (o_s_axi_bvalid && i_s_axi_bready)
      begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; latch always updates even when the pin is owned
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      p0_data_r <= `PPFS_RESET_BYTE;
      p1_data_r <= `PPFS_RESET_BYTE;
      p0_dir_r <= `PPFS_RESET_BYTE;
      p1_dir_r <= `PPFS_RESET_BYTE;
      p0_pull_r <= `PPFS_RESET_BYTE;
      p1_pull_r <= `PPFS_RESET_BYTE;
      p0_omode_r <= 4'h0;
      enables_r <= `PPFS_RESET_WORD;
      rmw_mode_r <= 1'b0;
    end
    else if (wr_fire && wstrb_r[0])
    begin
      unique case (awaddr_r[7:0])
        `PPFS_OFF_P0_DATA: p0_data_r <= wdata_r[7:0]; // R3 R8
        `PPFS_OFF_P1_DATA: p1_data_r <= wdata_r[7:0]; // R3 R8
        `PPFS_OFF_P0_DIR: p0_dir_r <= wdata_r[7:0]; // R7
        `PPFS_OFF_P1_DIR: p1_dir_r <= wdata_r[7:0]; // R7
        `PPFS_OFF_P0_PULL: p0_pull_r <= wdata_r[7:0]; // R7
        `PPFS_OFF_P1_PULL: p1_pull_r <= wdata_r[7:0]; // R7
        `PPFS_OFF_P0_OMODE: p0_omode_r <= wdata_r[5:2];
        `PPFS_OFF_RMW_READ: rmw_mode_r <= wdata_r[0];
        default: ;
      endcase
    end
    if (!i_srst && wr_fire && awaddr_r[7:0] == `PPFS_OFF_ENABLES)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wstrb_r[b])
        begin
          enables_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
        end
      end
    end
  end

  // Read channel: one cycle to accept, answer in the next
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= `PPFS_RESET_WORD;
      o_s_axi_rresp <= `PPFS_RESP_OKAY;
    end
    else
    begin
      o_s_axi_arready <= !o_s_axi_rvalid && !o_s_axi_arready;
      if (o_s_axi_arready && i_s_axi_arvalid)
      begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= `PPFS_RESP_OKAY;
        unique case (i_s_axi_araddr[7:0])
          `PPFS_OFF_P0_DATA: o_s_axi_rdata <= {24'h0, p0_read}; // R1 R2
          `PPFS_OFF_P1_DATA: o_s_axi_rdata <= {24'h0, p1_read}; // R1 R2
          `PPFS_OFF_P0_DIR: o_s_axi_rdata <= {24'h0, p0_dir_r};
          `PPFS_OFF_P1_DIR: o_s_axi_rdata <= {24'h0, p1_dir_r};
          `PPFS_OFF_P0_PULL: o_s_axi_rdata <= {24'h0, p0_pull_r};
          `PPFS_OFF_P1_PULL: o_s_axi_rdata <= {24'h0, p1_pull_r};
          `PPFS_OFF_P0_OMODE: o_s_axi_rdata <= {26'h0, p0_omode_r, 2'h0};
          `PPFS_OFF_ENABLES: o_s_axi_rdata <= enables_r;
          `PPFS_OFF_P0_OWNED: o_s_axi_rdata <= {24'h0, p0_owned};
          `PPFS_OFF_P1_OWNED: o_s_axi_rdata <= {24'h0, p1_owned};
          `PPFS_OFF_P0_PIN: o_s_axi_rdata <= {24'h0, i_p0_pin};
          `PPFS_OFF_P1_PIN: o_s_axi_rdata <= {24'h0, i_p1_pin};
          `PPFS_OFF_RMW_READ: o_s_axi_rdata <= {31'h0, rmw_mode_r};
          default:
          begin
            o_s_axi_rdata <= `PPFS_RESET_WORD;
            o_s_axi_rresp <= `PPFS_RESP_SLVERR;
          end
        endcase
      end
      else if (o_s_axi_rvalid && i_s_axi_rready)
      begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Registered pin and peripheral outputs; one cycle behind the selection
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_p0_out <= 8'h00;
      o_p0_oe <= 8'h00;
      o_p0_pullup <= 8'h00;
      o_p1_out <= 8'h00;
      o_p1_oe <= 8'h00;
      o_p1_pullup <= 8'h00;
      o_ext_irq1_input <= 1'b0;
      o_ext_irq2_input <= 1'b0;
      o_ext_irq3_input <= 1'b0;
      o_group4_source_input <= 8'h00;
      o_analog_input_sel <= 8'h00;
      o_timer0_count_input <= 1'b0;
      o_timer1_count_input <= 1'b0;
      o_reference_input_sel <= 1'b0;
      o_system_reset_request <= 1'b0;
    end
    else
    begin
      o_p0_out <= p0_out_nxt;
      o_p0_oe <= p0_oe_nxt; // R8
      o_p0_pullup <= p0_pull_nxt;
      o_p1_out <= p1_out_nxt;
      o_p1_oe <= p1_oe_nxt; // R8
      o_p1_pullup <= p1_pull_nxt;
      o_ext_irq2_input <= (p0_owner[0] == ppfs_pkg::PPFS_OWN_IRQ_IN) && i_p0_pin[0];
      o_ext_irq3_input <= (p0_owner[1] == ppfs_pkg::PPFS_OWN_IRQ_IN) && i_p0_pin[1];
      o_ext_irq1_input <= (p0_owner[7] == ppfs_pkg::PPFS_OWN_IRQ_IN) && i_p0_pin[7];
      o_group4_source_input <= {(p1_owner[0] == ppfs_pkg::PPFS_OWN_IRQ_IN) && i_p1_pin[0],
        2'b00, (p1_owner[1] == ppfs_pkg::PPFS_OWN_IRQ_IN) && i_p1_pin[1],
        (p1_owner[2] == ppfs_pkg::PPFS_OWN_IRQ_IN) && i_p1_pin[2],
        (p1_owner[3] == ppfs_pkg::PPFS_OWN_IRQ_IN) && i_p1_pin[3],
        (p1_owner[4] == ppfs_pkg::PPFS_OWN_IRQ_IN) && i_p1_pin[4],
        (p1_owner[5] == ppfs_pkg::PPFS_OWN_IRQ_IN) && i_p1_pin[5]};
      o_analog_input_sel <= {(p1_owner[5] == ppfs_pkg::PPFS_OWN_ANALOG),
        (p1_owner[4] == ppfs_pkg::PPFS_OWN_ANALOG),
        (p1_owner[3] == ppfs_pkg::PPFS_OWN_ANALOG),
        (p1_owner[2] == ppfs_pkg::PPFS_OWN_ANALOG),
        (p0_owner[5] == ppfs_pkg::PPFS_OWN_ANALOG),
        (p0_owner[4] == ppfs_pkg::PPFS_OWN_ANALOG),
        (p0_owner[3] == ppfs_pkg::PPFS_OWN_ANALOG),
        (p0_owner[2] == ppfs_pkg::PPFS_OWN_ANALOG)};
      o_timer1_count_input <= (p0_owner[6] == ppfs_pkg::PPFS_OWN_COUNT_IN) && i_p0_pin[6];
      o_timer0_count_input <= (p1_owner[6] == ppfs_pkg::PPFS_OWN_COUNT_IN) && i_p1_pin[6];
      o_reference_input_sel <= (p1_owner[6] == ppfs_pkg::PPFS_OWN_REF_IN);
      o_system_reset_request <= (p1_owner[7] == ppfs_pkg::PPFS_OWN_RESET) && !i_p1_pin[7];
    end
  end
endmodule

// *** ppfs_port_share_sva.sv ***
// Port-level assertions for the port pin share block
`timescale 1ns/1ps
module ppfs_port_share_sva (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_p0_pin,
  input wire logic [7:0] i_p1_pin,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic o_s_axi_bvalid,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic [7:0] o_p0_oe,
  input wire logic [7:0] o_p0_pullup,
  input wire logic o_ext_irq1_input,
  input wire logic o_ext_irq2_input,
  input wire logic o_ext_irq3_input,
  input wire logic [7:0] o_group4_source_input,
  input wire logic [7:0] o_analog_input_sel,
  input wire logic o_timer0_count_input,
  input wire logic o_timer1_count_input,
  input wire logic o_reference_input_sel,
  input wire logic o_system_reset_request
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  // Captured inputs only ever show a pin level seen one cycle earlier
  chk_irq2_follows_pin: assert property (o_ext_irq2_input |-> $past(i_p0_pin[0]))
    else $error("irq2 input high while its pin was low");
  chk_irq3_follows_pin: assert property (o_ext_irq3_input |-> $past(i_p0_pin[1]))
    else $error("irq3 input high while its pin was low");
  chk_reset_pin_low: assert property (o_system_reset_request |-> !$past(i_p1_pin[7]))
    else $error("reset request while the pin was high");
  // A pin taken as an input must not be driven by the port; the timer 1 count pin must have its pull-up
  chk_irq1_not_driven: assert property (o_ext_irq1_input |-> !o_p0_oe[7])
    else $error("P0.7 driven while serving irq1");
  chk_analog_not_driven: assert property (o_analog_input_sel[2] |-> !o_p0_oe[4])
    else $error("P0.4 driven while analog");
  chk_t1_auto_pullup: assert property (o_timer1_count_input |-> o_p0_pullup[6])
    else $error("timer1 count pin lacks pull-up");
  // Priority on shared pins, one analog channel at most, unused group 4 sources idle, read answer timing
  chk_group4_over_analog: assert property (o_group4_source_input[3] |-> !o_analog_input_sel[4])
    else $error("P1.2 owned twice");
  chk_t0_over_ref: assert property (o_timer0_count_input |-> !o_reference_input_sel)
    else $error("P1.6 owned twice");
  chk_analog_single: assert property ($onehot0(o_analog_input_sel))
    else $error("more than one analog channel owned");
  chk_group4_unused: assert property (o_group4_source_input[6:5] == 2'h0)
    else $error("unused group4 sources active");
  chk_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");

  cover property (o_ext_irq2_input);
  cover property (o_analog_input_sel != 8'h00);
  cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
endmodule

bind ppfs_port_share ppfs_port_share_sva u_sva (
  .i_core_clk, .i_srst, .i_p0_pin, .i_p1_pin, .i_s_axi_arvalid, .o_s_axi_arready,
  .o_s_axi_rvalid, .o_s_axi_bvalid, .o_s_axi_bresp, .o_p0_oe, .o_p0_pullup,
  .o_ext_irq1_input, .o_ext_irq2_input, .o_ext_irq3_input, .o_group4_source_input,
  .o_analog_input_sel, .o_timer0_count_input, .o_timer1_count_input,
  .o_reference_input_sel, .o_system_reset_request
);

// *** tb_ppfs_port_share.sv ***
// Self-checking bench for the port pin share block
`timescale 1ns/1ps
module tb_ppfs_port_share;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] p0_ext = 8'h00, p1_ext = 8'h00;
  logic i_pwm2_complement_output = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0] i_p0_pin, i_p1_pin, o_p0_out, o_p0_oe, o_p0_pullup, o_p1_out, o_p1_oe;
  logic [7:0] o_p1_pullup, o_analog_input_sel, o_group4_source_input;
  logic o_ext_irq1_input, o_ext_irq2_input, o_ext_irq3_input, o_timer0_count_input;
  logic o_timer1_count_input, o_reference_input_sel, o_system_reset_request;
  logic [23:0] status;
  int n_errors = 0;
  int n_compared = 0;
  // Enable words and the captured-input picture each must give, all pins high
  localparam logic [31:0] EN_TAB [13] = '{32'h7, 32'h207, 32'h7, 32'h60, 32'h20, 32'h580,
    32'h400, 32'hFF001010, 32'hFF003010, 32'hFF082018, 32'h900008, 32'hFF000000, 32'hFE000010};
  localparam logic [23:0] ST_TAB [13] = '{24'h700000, 24'h300000, 24'h700000, 24'h040000,
    24'h0, 24'h080000, 24'h020000, 24'h000400, 24'h004000, 24'h8, 24'h90, 24'h0, 24'h0};

  assign status = {o_system_reset_request, o_ext_irq1_input, o_ext_irq2_input,
    o_ext_irq3_input, o_timer0_count_input, o_timer1_count_input, o_reference_input_sel,
    1'b0, o_analog_input_sel, o_group4_source_input};

  ppfs_port_share #(.ADDR_W(8), .P17_IS_RESET(1'b1)) dut (
    .i_core_clk(clk), .i_srst(srst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_p0_pin, .i_p1_pin, .i_pwm2_complement_output, .o_p0_out, .o_p0_oe, .o_p0_pullup,
    .o_p1_out, .o_p1_oe, .o_p1_pullup, .o_ext_irq1_input, .o_ext_irq2_input,
    .o_ext_irq3_input, .o_group4_source_input, .o_analog_input_sel, .o_timer0_count_input,
    .o_timer1_count_input, .o_reference_input_sel, .o_system_reset_request
  );
  ppfs_pin_model u_p0 (.i_core_clk(clk), .i_out(o_p0_out), .i_oe(o_p0_oe),
    .i_pullup(o_p0_pullup), .i_ext_val(p0_ext), .i_ext_en(8'hFF), .o_pin(i_p0_pin));
  ppfs_pin_model u_p1 (.i_core_clk(clk), .i_out(o_p1_out), .i_oe(o_p1_oe),
    .i_pullup(o_p1_pullup), .i_ext_val(p1_ext), .i_ext_en(8'hFF), .o_pin(i_p1_pin));

  // 25 MHz core clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic conclude;
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64 && !bvalid; i++)
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    resp = bresp;
    bready <= 1'b0;
    if (i == 64)
    begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64 && !rvalid; i++)
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (i == 64)
    begin
      n_errors++;
      conclude();
    end
  endtask

  // Outputs trail register and pin changes by one cycle; leave margin
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  // Open-drain bits 5:2 in mode 0 let go of the line while the latch holds 1
  function automatic logic [7:0] f_oe(input logic [7:0] dir, input logic [7:0] d,
    input logic [7:0] m);
    return dir & ~(8'h3C & ~m & d);
  endfunction

  // Level a reader sees: the device where it drives, the board elsewhere
  function automatic logic [7:0] f_pin(input logic [7:0] oe, input logic [7:0] d,
    input logic [7:0] e);
    return (oe & d) | (~oe & e);
  endfunction

  initial
  begin
    logic [7:0] d, dir, m, e, pu, eo;
    d = 8'($urandom(32'h27A38A5F));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    // Every mapped word but P1 ownership (0x80, P1.7 reset) reads zero out of reset; holes answer with an error
    for (int k = 0; k < 13; k++)
    begin
      rd_reg(8'(k * 4));
      cmp(rd, (k == 9) ? 32'h80 : 32'h0);
      cmp(32'(resp), 32'h0);
    end
    rd_reg(8'h34);
    cmp(rd, 32'h0);
    cmp(32'(resp), 32'h2);
    rd_reg(8'h01);
    cmp(32'(resp), 32'h2);
    wr(8'h34, 32'hFFFFFFFF);
    cmp(32'(resp), 32'h2);
    // Random direction, data, mode and board levels through the read paths
    for (int k = 0; k < 8; k++)
    begin
      d = 8'($urandom);
      dir = 8'($urandom);
      m = 8'($urandom) & 8'h3C;
      e = 8'($urandom);
      pu = 8'($urandom);
      eo = f_oe(dir, d, m);
      @(posedge clk);
      p0_ext <= e;
      p1_ext <= e | 8'h80;
      wr(8'h00, 32'(d));
      wr(8'h04, 32'(d));
      wr(8'h08, 32'(dir));
      wr(8'h0C, 32'(dir));
      wr(8'h18, 32'(m));
      wr(8'h10, 32'(pu));
      wr(8'h30, 32'h0);
      settle();
      cmp(32'(o_p0_oe), 32'(eo));
      cmp(32'(o_p0_out & eo), 32'(d & eo));
      cmp(32'(o_p0_pullup), 32'(pu & ~dir));
      cmp(32'(o_p1_oe), 32'(dir & 8'h7F));
      cmp(32'(o_p1_pullup), 32'h80);
      cmp(32'(o_p1_out), 32'(d & 8'h7F));
      rd_reg(8'h00);
      cmp(rd, 32'(f_pin(eo, d, e)));
      rd_reg(8'h04);
      cmp(rd, 32'(f_pin(dir & 8'h7F, d, e | 8'h80)));
      wr(8'h30, 32'h1);
      rd_reg(8'h00);
      cmp(rd, 32'((dir & d) | (~dir & f_pin(eo, d, e))));
    end
    // Ownership table with every port in input mode and every pin high
    @(posedge clk);
    p0_ext <= 8'hFF;
    p1_ext <= 8'hFF;
    i_pwm2_complement_output <= 1'b1;
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h0);
    for (int k = 0; k < 13; k++)
    begin
      wr(8'h1C, EN_TAB[k]);
      settle();
      cmp(32'(status), 32'(ST_TAB[k]));
    end
    wr(8'h1C, 32'h200);
    settle();
    cmp(32'({o_p0_oe[7], o_p0_out[7]}), 32'h3);
    wr(8'h1C, 32'h60);
    settle();
    cmp(32'(o_p0_pullup), 32'h40);
    // Direction written while P0.4 is analog must wait for the release
    wr(8'h1C, 32'hFF001010);
    wr(8'h08, 32'hFF);
    wr(8'h18, 32'h3C);
    settle();
    cmp(32'(o_p0_oe), 32'hEF);
    wr(8'h1C, 32'h0);
    settle();
    cmp(32'(o_p0_oe), 32'hFF);
    @(posedge clk);
    p1_ext <= 8'h7F;
    settle();
    cmp(32'(o_system_reset_request), 32'h1);
    conclude();
  end
endmodule
